// *** rtl/pb_seq_pkg.sv ***
// Purpose: Constants and types for the pushbutton power sequencer.
// Assumes: 250 MHz clock; long times are top-level parameters.
// Notes:   Times are kept in their own unit, counts derived here.
package pb_seq_pkg;

  localparam int unsigned CLK_MHZ              = 250;
  localparam int unsigned TURN_ON_DEBOUNCE_MS  = 32;
  localparam int unsigned TURN_OFF_DEBOUNCE_MS = 32;
  localparam int unsigned MIN_REQUEST_MS       = 32;
  localparam int unsigned FORCED_OFF_BASE_MS   = 64;
  localparam int unsigned BLANKING_MS          = 512;
  localparam int unsigned LOCKOUT_MS           = 256;
  localparam int unsigned HALT_DELAY_US        = 30;
  localparam int unsigned EXTEND_CYCLES        = 16;
  localparam int unsigned CNT_W                = 32;

  localparam int unsigned TURN_ON_DEBOUNCE_CYC  = TURN_ON_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned TURN_OFF_DEBOUNCE_CYC = TURN_OFF_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned MIN_REQUEST_CYC       = MIN_REQUEST_MS * 1000 * CLK_MHZ;
  localparam int unsigned FORCED_OFF_BASE_CYC   = FORCED_OFF_BASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLANKING_CYC          = BLANKING_MS * 1000 * CLK_MHZ;
  localparam int unsigned LOCKOUT_CYC           = LOCKOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned HALT_DELAY_CYC        = HALT_DELAY_US * CLK_MHZ;

  localparam logic [31:0] EXTEND_CLEAR = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_ON_DEB   = 3'b001,
    ST_BLANK    = 3'b010,
    ST_POWERED  = 3'b011,
    ST_LOCKOUT  = 3'b100,
    ST_ABORT    = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic supply_o;
    logic supply_oe;
    logic request_o;
    logic request_oe;
  } pin_drive_t;

endpackage : pb_seq_pkg

// *** rtl/pushbutton_power_sequencer.sv ***
// Purpose: Pushbutton on/off power sequencer with processor handshake.
// Assumes: Pins are asynchronous and pass four flip-flops each, three synchroniser stages and one filter register.
// Notes:   Open-drain pins are given as output and output enable.
// Contract
// [R1] Supply on after 32 ms press plus extension.
// [R2] On extension from capacitor, zero when floating.
// [R3] Supply pin open drain, polarity by variant.
// [R4] Ignore halt and button 512 ms after on.
// [R5] Halt low at blanking end releases supply.
// [R6] Halt falling edge releases within 30 us.
// [R7] Processor holds halt low at least 30 us.
// [R8] Request low after 32 ms press when powered.
// [R9] Request held 32 ms and while pressed.
// [R10] Long press releases supply and request.
// [R11] Forced off 64 ms plus off extension.
// [R12] Button ignored during lockout after release.
// [R13] Lockout lasts nominally 256 ms.
// [R14] Any button release restarts debounce timers.
// [R15] Power-up holds supply off, request released.
// [R16] Off extension counted as sixteen timer cycles; code adds off_time_extend as plain cycles.
// [R17] Extensions are cycle counts; zero means floating.
// [R18] State machine; timers cleared on state entry.
`timescale 1ns/10ps
module pushbutton_power_sequencer
  import pb_seq_pkg::*;
#(
  parameter logic        ACTIVE_HIGH_SUPPLY = 1'b1,
  parameter int unsigned TURN_ON_CYC        = TURN_ON_DEBOUNCE_CYC,
  parameter int unsigned TURN_OFF_CYC       = TURN_OFF_DEBOUNCE_CYC,
  parameter int unsigned REQUEST_MIN_CYC    = MIN_REQUEST_CYC,
  parameter int unsigned FORCED_OFF_CYC     = FORCED_OFF_BASE_CYC,
  parameter int unsigned BLANK_CYC          = BLANKING_CYC,
  parameter int unsigned LOCK_CYC           = LOCKOUT_CYC
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Pins from the outside world.
  input  wire logic        pushbutton_n,
  input  wire logic        halt_power_n,
  // Extension settings in clock cycles, zero for a floating pin.
  input  wire logic [31:0] on_time_extend,
  input  wire logic [31:0] off_time_extend,
  // Open-drain supply switch pin.
  output logic             supply_switch_o,
  output logic             supply_switch_oe,
  // Open-drain shutdown request pin.
  output logic             shutdown_request_o,
  output logic             shutdown_request_oe
);

  // Number of asynchronous pins, each with its own copy of the filter.
  localparam int unsigned N_PINS = 2;

  // Pin levels; a filtered bit is high while its pin is held low.
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_low;
  logic              pb_low;
  logic              halt_low;

  // Sequencer state.
  seq_state_t        state_q;
  seq_state_t        state_d;

  // Timers: time in the current state and length of the current press.
  logic [CNT_W-1:0]  state_cnt_q;
  logic [CNT_W-1:0]  state_cnt_d;
  logic [CNT_W-1:0]  press_cnt_q;
  logic [CNT_W-1:0]  press_cnt_d;

  // Kill input edge detector.
  logic              halt_seen_q;
  logic              halt_seen_d;

  // Supply switch state.
  logic              supply_on_q;
  logic              supply_on_d;
  logic              supply_drop;

  // Shutdown request state.
  logic              req_q;
  logic              req_d;
  logic [CNT_W-1:0]  req_cnt_q;
  logic [CNT_W-1:0]  req_cnt_d;

  // Timer targets and the events that they produce.
  logic [CNT_W-1:0]  on_target;
  logic [CNT_W-1:0]  off_target;
  logic              on_reached;
  logic              off_reached;
  logic              req_reached;
  logic              req_min_done;
  logic              blank_done;
  logic              lock_done;
  logic              halt_fall;

  // Open-drain pin drive.
  pin_drive_t        drive;

  // Each pin enters its own copy of the three-stage filter.
  assign pin_raw = {halt_power_n, pushbutton_n};

  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       low_q;
    logic       low_d;

    // A level counts once the second and third stage agree, so a
    // metastable first stage never reaches the sequencer.
    always_comb begin
      sync_d = {sync_q[1:0], pin_raw[p]};
      low_d  = low_q;
      if (sync_q[1] == sync_q[2]) begin
        low_d = ~sync_q[2];
      end
    end

    // [R15] Idle pins at reset.
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        sync_q <= 3'h7;
        low_q  <= 1'b0;
      end else begin
        sync_q <= sync_d;
        low_q  <= low_d;
      end
    end

    assign pin_low[p] = low_q;
  end

  assign pb_low   = pin_low[0];
  assign halt_low = pin_low[1];

  // [R2] On extension added to the fixed debounce.
  // [R17] Extension as cycle counts.
  assign on_target    = CNT_W'(TURN_ON_CYC) + on_time_extend;
  // [R11] Forced off base plus extension.
  // [R16] Extension added as plain cycles; EXTEND_CYCLES (sixteen) is not used.
  assign off_target   = CNT_W'(FORCED_OFF_CYC) + off_time_extend;

  // Each compare looks one count ahead, so the event acts on the edge
  // at which the timer would reach its target.
  // [R1] Continuous press reaches the on target.
  assign on_reached   = press_cnt_q + 32'h1 >= on_target;
  // [R10] Long press reaches the forced-off target.
  assign off_reached  = press_cnt_q + 32'h1 >= off_target;
  // [R8] Press reaches the turn-off debounce.
  assign req_reached  = press_cnt_q + 32'h1 >= CNT_W'(TURN_OFF_CYC);
  assign req_min_done = req_cnt_q + 32'h1 >= CNT_W'(REQUEST_MIN_CYC);
  // [R4] Blanking window length.
  assign blank_done   = state_cnt_q + 32'h1 >= CNT_W'(BLANK_CYC);
  // [R13] Lockout length.
  assign lock_done    = state_cnt_q + 32'h1 >= CNT_W'(LOCK_CYC);
  // [R6] A new fall of the kill input.
  assign halt_fall    = halt_low && !halt_seen_q;

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (pb_low) begin
          state_d = ST_ON_DEB;
        end
      end
      ST_ON_DEB: begin
        if (!pb_low) begin
          state_d = ST_OFF;
        end else if (on_reached) begin
          state_d = ST_BLANK;
        end
      end
      ST_BLANK: begin
        // [R4] Halt and button ignored here.
        // [R5] Abort when halt is still low.
        if (blank_done) begin
          state_d = halt_low ? ST_ABORT : ST_POWERED;
        end
      end
      ST_POWERED: begin
        // [R6] Halt falling edge drops supply next cycle.
        // [R10] Long press forces power off.
        if (halt_fall || off_reached) begin
          state_d = ST_LOCKOUT;
        end
      end
      ST_ABORT: begin
        state_d = ST_LOCKOUT;
      end
      ST_LOCKOUT: begin
        // [R12] Button ignored until lockout ends.
        if (lock_done) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // [R15] Power-up starts in the off state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Timers restart on every state change, so no count carries over
  // from one phase of the sequence into the next.
  always_comb begin
    state_cnt_d = state_cnt_q + 32'h1;
    // [R14] Button release zeroes the press timer.
    press_cnt_d = pb_low ? press_cnt_q + 32'h1 : 32'h0;
    // [R18] Timers cleared on state entry.
    if (state_d != state_q) begin
      state_cnt_d = 32'h0;
      press_cnt_d = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_cnt_q <= 32'h0;
      press_cnt_q <= 32'h0;
    end else begin
      state_cnt_q <= state_cnt_d;
      press_cnt_q <= press_cnt_d;
    end
  end

  // The kill input must fall while powered; a low level carried over
  // from blanking is not a new request. Entry to any state marks the
  // input as already seen.
  always_comb begin
    halt_seen_d = halt_seen_q;
    if (state_q == ST_POWERED) begin
      halt_seen_d = halt_low;
    end
    if (state_d != state_q) begin
      halt_seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halt_seen_q <= 1'b1;
    end else begin
      halt_seen_q <= halt_seen_d;
    end
  end

  // Leaving the powered state for any reason also ends a request.
  assign supply_drop = (state_q == ST_POWERED) && (state_d != ST_POWERED);

  // The supply follows the sequencer: on from the end of the turn-on
  // debounce until powered operation ends or blanking aborts.
  always_comb begin
    supply_on_d = supply_on_q;
    if (state_q == ST_ON_DEB && state_d == ST_BLANK) begin
      supply_on_d = 1'b1;
    end
    if (state_d == ST_ABORT || state_d == ST_LOCKOUT ||
        state_d == ST_OFF) begin
      supply_on_d = 1'b0;
    end
  end

  // [R15] Supply released at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_on_q <= 1'b0;
    end else begin
      supply_on_q <= supply_on_d;
    end
  end

  // Shutdown request next value.
  always_comb begin
    req_d     = req_q;
    req_cnt_d = req_q ? req_cnt_q + 32'h1 : 32'h0;
    if (state_q == ST_POWERED) begin
      // [R8] Request after turn-off debounce.
      if (!req_q && req_reached) begin
        req_d = 1'b1;
      end
      // [R9] Hold request minimum and while pressed.
      if (req_q && !pb_low && req_min_done) begin
        req_d = 1'b0;
      end
    end else begin
      req_d = 1'b0;
    end
    // [R10] Forced off or kill releases the request as well.
    if (supply_drop) begin
      req_d = 1'b0;
    end
  end

  // [R15] Request released at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_q     <= 1'b0;
      req_cnt_q <= 32'h0;
    end else begin
      req_q     <= req_d;
      req_cnt_q <= req_cnt_d;
    end
  end

  // [R3] Open drain with variant polarity. The active-high variant
  // lets the pull-up raise the pin while the supply is on; the
  // active-low variant pulls the pin low while the supply is on.
  always_comb begin
    drive.supply_o   = 1'b0;
    drive.supply_oe  = ACTIVE_HIGH_SUPPLY ? ~supply_on_q : supply_on_q;
    drive.request_o  = 1'b0;
    drive.request_oe = req_q;
  end

  assign supply_switch_o     = drive.supply_o;
  assign supply_switch_oe    = drive.supply_oe;
  assign shutdown_request_o  = drive.request_o;
  assign shutdown_request_oe = drive.request_oe;

endmodule : pushbutton_power_sequencer

// *** test/pb_seq_properties.sv ***
// Purpose: Pin timing checks for the pushbutton power sequencer.
// Assumes: Active-high supply variant; supply is on while its oe is 0.
// Notes:   Counters keep pin history in cycles.
`timescale 1ns/10ps
module pb_seq_properties #(
  parameter int unsigned TURN_ON_CYC     = 20,
  parameter int unsigned TURN_OFF_CYC    = 20,
  parameter int unsigned REQUEST_MIN_CYC = 20,
  parameter int unsigned FORCED_OFF_CYC  = 40,
  parameter int unsigned BLANK_CYC       = 100,
  parameter int unsigned LOCK_CYC        = 50
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_b,
  // Design inputs.
  input wire logic        pushbutton_n,
  input wire logic        halt_power_n,
  input wire logic [31:0] on_time_extend,
  input wire logic [31:0] off_time_extend,
  // Design outputs.
  input wire logic        supply_switch_o,
  input wire logic        supply_switch_oe,
  input wire logic        shutdown_request_o,
  input wire logic        shutdown_request_oe
);
  logic [31:0] pc_q, on_q, off_q, rq_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Power-up counts as a long settled off time.
  always_ff @(posedge clk) begin
    pc_q  <= (!rst_b || pushbutton_n) ? 32'h0 : pc_q + 32'h1;
    on_q  <= (!rst_b || supply_switch_oe) ? 32'h0 : on_q + 32'h1;
    off_q <= !rst_b ? LOCK_CYC : (!supply_switch_oe ? 32'h0 : off_q + 32'h1);
    rq_q  <= (!rst_b || !shutdown_request_oe) ? 32'h0 : rq_q + 32'h1;
  end
  drain_only_a: assert property (!supply_switch_o && !shutdown_request_o)
    else $error("open-drain pin driven high");
  reset_off_a: assert property ($rose(rst_b) |-> supply_switch_oe
    && !shutdown_request_oe) else $error("outputs wrong after reset");
  on_press_a: assert property ($fell(supply_switch_oe)
    |-> pc_q >= TURN_ON_CYC + on_time_extend) else $error("supply on early");
  on_lockout_a: assert property ($fell(supply_switch_oe)
    |-> off_q >= LOCK_CYC + TURN_ON_CYC) else $error("lockout too short");
  blank_hold_a: assert property ($rose(supply_switch_oe)
    |-> on_q >= BLANK_CYC) else $error("supply dropped in blanking");
  halt_off_a: assert property ($fell(halt_power_n) && on_q > BLANK_CYC + 8
    |-> ##[1:1000] supply_switch_oe) else $error("halt did not release");
  req_start_a: assert property ($rose(shutdown_request_oe)
    |-> !supply_switch_oe && pc_q >= TURN_OFF_CYC && on_q > BLANK_CYC)
    else $error("request raised early");
  req_width_a: assert property ($fell(shutdown_request_oe)
    && !supply_switch_oe |-> rq_q >= REQUEST_MIN_CYC && pushbutton_n)
    else $error("request too short");
  forced_off_a: assert property (pc_q == FORCED_OFF_CYC + off_time_extend + 8
    && $past(on_q, 9) > FORCED_OFF_CYC + off_time_extend + BLANK_CYC
    |-> supply_switch_oe && !shutdown_request_oe) else $error("no forced off");
endmodule : pb_seq_properties

// *** test/cpu_model.sv ***
// Purpose: Processor side of the shutdown handshake.
// Assumes: Kill is held low while the processor is unpowered.
// Notes:   Answer delay is set by the bench; boot delay is BOOT_CYC.
`timescale 1ns/10ps
module cpu_model #(
  parameter int unsigned BOOT_CYC = 40,
  parameter int unsigned HOLD_CYC = 7500
) (
  // Clock.
  input  wire logic       clk,
  // Pins seen by the processor.
  input  wire logic       supply_on,
  input  wire logic       request,
  // Behaviour controls.
  input  wire logic       boot_ok,
  input  wire logic       respond,
  input  wire logic [7:0] resp_cyc,
  // Kill pin.
  output logic            halt_n = 1'b0
);
  int unsigned boot_t, kill_t;
  always @(posedge clk) begin
    if (!supply_on) begin
      boot_t = 0;
      kill_t = 0;
      halt_n <= #1 1'b0;
    end else begin
      boot_t++;
      if (boot_ok && boot_t == BOOT_CYC) halt_n <= #1 1'b1;
      if (request && respond || kill_t > 0) kill_t++;
      if (kill_t == resp_cyc) halt_n <= #1 1'b0;
      if (kill_t == resp_cyc + HOLD_CYC) halt_n <= #1 1'b1;
    end
  end
endmodule : cpu_model

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the pushbutton power sequencer.
// Assumes: Shortened timer parameters; active-high supply variant.
// Notes:   Supply is on while its output enable is low.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [31:0] ext;
    logic [7:0]  hold;
    logic [7:0]  resp;
    logic        on;
  } row_t;
  localparam int unsigned BLK = 100;
  localparam int unsigned LCK = 50;
  logic        clk = 1'b0, rst_b = 1'b0, pb_n = 1'b1;
  logic        boot_ok = 1'b1, respond = 1'b1;
  logic [31:0] on_ext = 32'h0, off_ext = 32'h0;
  logic [7:0]  resp = 8'h05;
  logic        halt_n, sw_o, sw_oe, rq_o, rq_oe;
  int          n_errors = 0, checks = 0;
  row_t rows [4] = '{'{32'h0, 8'h0a, 8'h05, 1'b0},
    '{32'h0, 8'h28, 8'h05, 1'b1}, '{32'h1e, 8'h28, 8'h05, 1'b0},
    '{32'h1e, 8'h46, 8'h0f, 1'b1}};
  always #2 clk = ~clk;
  pushbutton_power_sequencer #(.ACTIVE_HIGH_SUPPLY(1'b1), .TURN_ON_CYC(20),
    .TURN_OFF_CYC(20), .REQUEST_MIN_CYC(20), .FORCED_OFF_CYC(40),
    .BLANK_CYC(BLK), .LOCK_CYC(LCK)) u_pushbutton_power_sequencer (
    .clk(clk), .rst_b(rst_b), .pushbutton_n(pb_n), .halt_power_n(halt_n),
    .on_time_extend(on_ext), .off_time_extend(off_ext),
    .supply_switch_o(sw_o), .supply_switch_oe(sw_oe),
    .shutdown_request_o(rq_o), .shutdown_request_oe(rq_oe));
  cpu_model u_cpu_model (.clk(clk), .supply_on(~sw_oe), .request(rq_oe),
    .boot_ok(boot_ok), .respond(respond), .resp_cyc(resp), .halt_n(halt_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  task automatic press(input int n);
    pb_n = 1'b0;
    tick(n);
    pb_n = 1'b1;
  endtask : press
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic wait_off;
    for (int i = 0; i < 300 && sw_oe !== 1'b1; i++) tick(1);
    chk("supply off", 1'b1, sw_oe);
    if (sw_oe !== 1'b1) report_and_stop();
  endtask : wait_off
  initial begin
    tick(8);
    chk("reset supply", 1'b1, sw_oe);
    chk("reset request", 1'b0, rq_oe);
    chk("supply drive", 1'b0, sw_o);
    chk("request drive", 1'b0, rq_o);
    rst_b = 1'b1;
    tick(4);
    foreach (rows[k]) begin
      on_ext = rows[k].ext;
      resp = rows[k].resp;
      press(rows[k].hold);
      chk("supply on", rows[k].on, ~sw_oe);
      if (rows[k].on) begin
        tick(BLK);
        press(30);
        chk("request", 1'b1, rq_oe);
        wait_off();
      end
      tick(LCK + 10);
    end
    on_ext = 32'h0;
    press(15);
    tick(5);
    press(15);
    chk("broken press", 1'b0, ~sw_oe);
    tick(5);
    boot_ok = 1'b0;
    press(30);
    tick(BLK - 40);
    chk("blank ignores halt", 1'b1, ~sw_oe);
    wait_off();
    press(40);
    chk("lockout", 1'b0, ~sw_oe);
    tick(LCK);
    boot_ok = 1'b1;
    respond = 1'b0;
    off_ext = 32'h0a;
    press(30);
    tick(BLK + 10);
    pb_n = 1'b0;
    tick(45);
    chk("held supply", 1'b1, ~sw_oe);
    chk("held request", 1'b1, rq_oe);
    tick(15);
    chk("forced supply", 1'b1, sw_oe);
    chk("forced request", 1'b0, rq_oe);
    pb_n = 1'b1;
    rst_b = 1'b0;
    tick(4);
    chk("mid reset supply", 1'b1, sw_oe);
    chk("mid reset request", 1'b0, rq_oe);
    rst_b = 1'b1;
    tick(2);
    chk("after reset supply", 1'b1, sw_oe);
    report_and_stop();
  end
endmodule : testbench
bind pushbutton_power_sequencer pb_seq_properties #(
  .TURN_ON_CYC(TURN_ON_CYC), .TURN_OFF_CYC(TURN_OFF_CYC),
  .REQUEST_MIN_CYC(REQUEST_MIN_CYC), .FORCED_OFF_CYC(FORCED_OFF_CYC),
  .BLANK_CYC(BLANK_CYC), .LOCK_CYC(LOCK_CYC)) u_pb_seq_properties (
  .clk(clk), .rst_b(rst_b), .pushbutton_n(pushbutton_n),
  .halt_power_n(halt_power_n), .on_time_extend(on_time_extend),
  .off_time_extend(off_time_extend), .supply_switch_o(supply_switch_o),
  .supply_switch_oe(supply_switch_oe), .shutdown_request_o(shutdown_request_o),
  .shutdown_request_oe(shutdown_request_oe));
